// ==== ndai_pkg.sv ====
// Package of constants for the navigation discrete annunciator I/O block
package ndai_pkg;
   // APB register offsets (byte addresses)
   localparam logic [11:0] NDAI_CTRL_OFS = 12'h000;
   localparam logic [11:0] NDAI_NAVST_OFS = 12'h004;
   localparam logic [11:0] NDAI_STAT_OFS = 12'h008;
   localparam logic [11:0] NDAI_PRESET_OFS = 12'h00C;
   // Control register fields
   localparam int NDAI_CTRL_SINGLE_IND_BIT = 0;
   localparam int NDAI_CTRL_NAV_SRC_BIT = 1;
   localparam int NDAI_CTRL_COURSE_HOLD_BIT = 2;
   localparam int NDAI_CTRL_FULL_SCALE_LSB = 4;
   localparam logic [31:0] NDAI_CTRL_RESET = 32'h0000_0001;
   // Navigation status register fields
   localparam int NDAI_NS_NEW_MSG_BIT = 0;
   localparam int NDAI_NS_MSG_ACTIVE_BIT = 1;
   localparam int NDAI_NS_TURN_NEAR_BIT = 2;
   localparam int NDAI_NS_TURNING_BIT = 3;
   localparam int NDAI_NS_ALARM_SET_BIT = 4;
   localparam int NDAI_NS_IN_ALARM_BIT = 5;
   localparam int NDAI_NS_ARRIVAL_NEAR_BIT = 6;
   localparam int NDAI_NS_APPR_NAV_BIT = 7;
   localparam int NDAI_NS_TERM_30NM_BIT = 8;
   localparam int NDAI_NS_APPR_ACTIVE_BIT = 9;
   localparam int NDAI_NS_POS_ERR_BIT = 10;
   localparam int NDAI_NS_NO_INTEG_BIT = 11;
   localparam int NDAI_NS_SAT_APPR_BIT = 12;
   localparam int NDAI_NS_LANDING_CH_BIT = 13;
   localparam int NDAI_NS_SEQUENCING_SUSPENDED_BIT = 14;
   localparam int NDAI_NS_LAT_VALID_BIT = 15;
   localparam int NDAI_NS_VERT_VALID_BIT = 16;
   localparam logic [31:0] NDAI_NAVST_RESET = 32'h0000_0000;
   // Full scale codes, tenths of a nautical mile
   localparam logic [7:0] NDAI_FS_1P0NM = 8'h0A;
   localparam logic [7:0] NDAI_FS_0P3NM = 8'h03;
   localparam logic [7:0] NDAI_FS_RESET = 8'h32;
   // Timing
   localparam int NDAI_CLK_HZ = 50_000_000;
   localparam int NDAI_PULSE_MS = 1;
   localparam int NDAI_PERIOD_MS = 1000;
   localparam int NDAI_ALARM_S = 10;
   localparam int NDAI_DEBOUNCE_US = 5000;
   localparam int NDAI_FLASH_MS = 500;
   localparam int NDAI_PULSE_CYC = NDAI_CLK_HZ / 1000 * NDAI_PULSE_MS;
   localparam int NDAI_PERIOD_CYC = NDAI_CLK_HZ / 1000 * NDAI_PERIOD_MS;
   localparam int NDAI_DEBOUNCE_CYC = NDAI_CLK_HZ / 1_000_000 * NDAI_DEBOUNCE_US;
   localparam int NDAI_FLASH_CYC = NDAI_CLK_HZ / 1000 * NDAI_FLASH_MS;
   localparam int NDAI_PRESET_DEPTH = 8;
   typedef enum logic [1:0] {
      NDAI_SW_IDLE = 2'b00,
      NDAI_SW_LOW = 2'b01,
      NDAI_SW_HELD = 2'b11,
      NDAI_SW_REL = 2'b10
   } ndai_sw_state_t;
endpackage

// ==== ndai_preset_mem.sv ====
// Small memory holding the preset radio frequencies
`timescale 1ns/100ps
module ndai_preset_mem
   import ndai_pkg::*;
#(
   parameter int DEPTH = NDAI_PRESET_DEPTH,
   parameter int WIDTH = 20,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic pclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// ==== ndai_nav_discrete_io.sv ====
// Discrete annunciator and switch logic with APB register access
`timescale 1ns/100ps
module ndai_nav_discrete_io
   import ndai_pkg::*;
#(
   parameter int PERIOD_CYC = NDAI_PERIOD_CYC,
   parameter int PULSE_CYC = NDAI_PULSE_CYC,
   parameter int FLASH_CYC = NDAI_FLASH_CYC,
   parameter int DEBOUNCE_CYC = NDAI_DEBOUNCE_CYC,
   parameter int ALARM_SEC = NDAI_ALARM_S,
   parameter int FREQ_W = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nav_source_toggle_in,
   input wire logic course_mode_toggle_in,
   input wire logic preset_recall_in,
   input wire logic sim_select_in,
   output logic message_lamp_out,
   output logic waypoint_lamp_out,
   output logic terminal_lamp_out,
   output logic approach_lamp_out,
   output logic integrity_lamp_out,
   output logic radio_source_lamp_out,
   output logic satnav_source_lamp_out,
   output logic course_hold_lamp_out,
   output logic approach_gain_out,
   output logic guidance_select_out,
   output logic lateral_high_current_flag_out,
   output logic vertical_high_current_flag_out,
   output logic time_mark_out
);
   localparam int AW = $clog2(NDAI_PRESET_DEPTH);

   logic [31:0] ctrl_ff;
   logic [31:0] navst_ff;
   logic single_ind;
   logic sat_sel_ff;
   logic hold_ff;
   logic [7:0] full_scale;
   logic sim_mode_ff;
   logic sim_taken_ff;
   logic [FREQ_W-1:0] standby_ff;
   logic [AW-1:0] recall_idx_ff;
   logic [AW-1:0] nxt_recall_idx;
   logic [1:0] recall_load_ff;
   logic [FREQ_W-1:0] mem_rdata;
   logic [2:0] sw_raw;
   logic [2:0] sw_fall;
   logic wr_en;
   logic rd_en;
   logic [31:0] nxt_prdata;
   logic [31:0] prdata_ff;

   assign single_ind = ctrl_ff[NDAI_CTRL_SINGLE_IND_BIT];
   assign full_scale = ctrl_ff[NDAI_CTRL_FULL_SCALE_LSB +: 8];
   assign sw_raw = {preset_recall_in, course_mode_toggle_in, nav_source_toggle_in};

   // APB slave: zero wait states, unmapped addresses answer with pslverr
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~(paddr == NDAI_CTRL_OFS || paddr == NDAI_NAVST_OFS
      || paddr == NDAI_STAT_OFS || paddr == NDAI_PRESET_OFS);
   assign prdata = prdata_ff;

   always_comb begin
      nxt_prdata = 32'h0000_0000;
      case (paddr)
         NDAI_CTRL_OFS: nxt_prdata = {ctrl_ff[31:3], hold_ff, sat_sel_ff, ctrl_ff[0]};
         NDAI_NAVST_OFS: nxt_prdata = navst_ff;
         NDAI_STAT_OFS: nxt_prdata = {19'h0_0000, sim_mode_ff, message_lamp_out,
            waypoint_lamp_out, terminal_lamp_out, approach_lamp_out, integrity_lamp_out,
            radio_source_lamp_out, satnav_source_lamp_out, course_hold_lamp_out,
            approach_gain_out, guidance_select_out, time_mark_out};
         NDAI_PRESET_OFS: nxt_prdata = {{(32 - FREQ_W - AW){1'b0}}, recall_idx_ff, standby_ff};
         default: nxt_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata_ff <= nxt_prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= NDAI_CTRL_RESET;
         ctrl_ff[NDAI_CTRL_FULL_SCALE_LSB +: 8] <= NDAI_FS_RESET;
      end else if (wr_en && paddr == NDAI_CTRL_OFS) begin
         ctrl_ff <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         navst_ff <= NDAI_NAVST_RESET;
      end else if (wr_en && paddr == NDAI_NAVST_OFS) begin
         navst_ff <= pwdata;
      end
   end

   // Switch inputs: sync, debounce, one event per fall
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sw
         logic [1:0] sync_ff;
         logic [$clog2(DEBOUNCE_CYC+1)-1:0] cnt_ff;
         ndai_sw_state_t st_ff;
         ndai_sw_state_t nxt_st;
         logic stable;

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync_ff <= 2'b11;
            end else begin
               sync_ff <= {sync_ff[0], sw_raw[gi]};
            end
         end

         // Input must hold its level for the whole debounce time
         assign stable = (cnt_ff == ($clog2(DEBOUNCE_CYC+1))'(DEBOUNCE_CYC));

         always_comb begin
            nxt_st = st_ff;
            case (st_ff)
               NDAI_SW_IDLE: if (!sync_ff[1]) nxt_st = NDAI_SW_LOW;
               NDAI_SW_LOW: begin
                  if (sync_ff[1]) nxt_st = NDAI_SW_IDLE;
                  else if (stable) nxt_st = NDAI_SW_HELD;
               end
               NDAI_SW_HELD: if (sync_ff[1]) nxt_st = NDAI_SW_REL;
               NDAI_SW_REL: begin
                  if (!sync_ff[1]) nxt_st = NDAI_SW_HELD;
                  else if (stable) nxt_st = NDAI_SW_IDLE;
               end
               default: nxt_st = NDAI_SW_IDLE;
            endcase
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               st_ff <= NDAI_SW_IDLE;
               cnt_ff <= '0;
            end else begin
               st_ff <= nxt_st;
               if (nxt_st != st_ff || st_ff == NDAI_SW_IDLE || st_ff == NDAI_SW_HELD) begin
                  cnt_ff <= '0;
               end else if (!stable) begin
                  cnt_ff <= cnt_ff + 1'b1;
               end
            end
         end

         assign sw_fall[gi] = (st_ff == NDAI_SW_LOW) && stable;
      end
   endgenerate

   // Source and course mode; a toggle pulse wins over a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sat_sel_ff <= 1'b1;
         hold_ff <= 1'b0;
      end else begin
         if (sw_fall[0]) begin
            sat_sel_ff <= ~sat_sel_ff;
         end else if (wr_en && paddr == NDAI_CTRL_OFS) begin
            sat_sel_ff <= pwdata[NDAI_CTRL_NAV_SRC_BIT];
         end
         if (sw_fall[1]) begin
            hold_ff <= ~hold_ff;
         end else if (wr_en && paddr == NDAI_CTRL_OFS) begin
            hold_ff <= pwdata[NDAI_CTRL_COURSE_HOLD_BIT];
         end
      end
   end

   // Simulation select is caught once, on the first edge after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sim_taken_ff <= 1'b0;
         sim_mode_ff <= 1'b0;
      end else if (!sim_taken_ff) begin
         sim_taken_ff <= 1'b1;
         sim_mode_ff <= ~sim_select_in;
      end
   end

   // Preset recall: next entry, wrapping, into the standby slot; load waits for the memory
   assign nxt_recall_idx = (recall_idx_ff == AW'(NDAI_PRESET_DEPTH - 1)) ? '0 :
      recall_idx_ff + 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         recall_idx_ff <= '0;
         recall_load_ff <= 2'b00;
         standby_ff <= '0;
      end else begin
         // Read data lags the new index by one edge, so the load needs two
         recall_load_ff <= {recall_load_ff[0], sw_fall[2]};
         if (sw_fall[2]) begin
            recall_idx_ff <= nxt_recall_idx;
         end
         if (recall_load_ff[1]) begin
            standby_ff <= mem_rdata;
         end
      end
   end

   ndai_preset_mem #(
      .DEPTH(NDAI_PRESET_DEPTH),
      .WIDTH(FREQ_W),
      .AW(AW)
   ) u_preset_mem (
      .pclk(pclk),
      .we(wr_en && paddr == NDAI_PRESET_OFS),
      .waddr(pwdata[FREQ_W +: AW]),
      .wdata(pwdata[FREQ_W-1:0]),
      .raddr(recall_idx_ff),
      .rdata(mem_rdata)
   );

   // Time mark: fixed 1 ms pulse each second; one divider also makes the seconds tick
   logic [$clog2(PERIOD_CYC)-1:0] sec_cnt_ff;
   logic sec_tick;
   assign sec_tick = (sec_cnt_ff == ($clog2(PERIOD_CYC))'(PERIOD_CYC - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_cnt_ff <= '0;
         time_mark_out <= 1'b0;
      end else begin
         sec_cnt_ff <= sec_tick ? '0 : sec_cnt_ff + 1'b1;
         time_mark_out <= (sec_cnt_ff < ($clog2(PERIOD_CYC))'(PULSE_CYC));
      end
   end

   // Common flash phase for every flashing lamp
   logic [$clog2(FLASH_CYC)-1:0] flash_cnt_ff;
   logic flash_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_cnt_ff <= '0;
         flash_ff <= 1'b0;
      end else if (flash_cnt_ff == ($clog2(FLASH_CYC))'(FLASH_CYC - 1)) begin
         flash_cnt_ff <= '0;
         flash_ff <= ~flash_ff;
      end else begin
         flash_cnt_ff <= flash_cnt_ff + 1'b1;
      end
   end

   // Arrival alarm: entering the radius starts a ten second flash
   logic in_alarm_d_ff;
   logic [$clog2(ALARM_SEC+2)-1:0] alarm_sec_ff;
   logic alarm_flash;
   assign alarm_flash = (alarm_sec_ff != '0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_alarm_d_ff <= 1'b0;
         alarm_sec_ff <= '0;
      end else begin
         in_alarm_d_ff <= navst_ff[NDAI_NS_IN_ALARM_BIT];
         if (navst_ff[NDAI_NS_ALARM_SET_BIT] && navst_ff[NDAI_NS_IN_ALARM_BIT]
               && !in_alarm_d_ff) begin
            alarm_sec_ff <= ($clog2(ALARM_SEC+2))'(ALARM_SEC + 1);
         end else if (sec_tick && alarm_flash) begin
            alarm_sec_ff <= alarm_sec_ff - 1'b1;
         end
      end
   end

   // Lamp conditions, active high before the output inversion
   logic msg_on, wpt_on, term_on, appr_on, integ_on;
   logic radio_on, sat_on, hold_on, gain_on, guide_on;

   always_comb begin
      msg_on = navst_ff[NDAI_NS_NEW_MSG_BIT] ? flash_ff :
         navst_ff[NDAI_NS_MSG_ACTIVE_BIT];
      if (navst_ff[NDAI_NS_TURNING_BIT]) begin
         wpt_on = 1'b1;
      end else if (navst_ff[NDAI_NS_TURN_NEAR_BIT]) begin
         wpt_on = flash_ff;
      end else if (alarm_flash) begin
         wpt_on = flash_ff;
      end else if (!navst_ff[NDAI_NS_ALARM_SET_BIT] && navst_ff[NDAI_NS_ARRIVAL_NEAR_BIT]) begin
         wpt_on = flash_ff;
      end else begin
         wpt_on = 1'b0;
      end
      term_on = navst_ff[NDAI_NS_APPR_NAV_BIT] && navst_ff[NDAI_NS_TERM_30NM_BIT]
         && (full_scale <= NDAI_FS_1P0NM);
      appr_on = navst_ff[NDAI_NS_APPR_NAV_BIT] && navst_ff[NDAI_NS_APPR_ACTIVE_BIT];
      integ_on = navst_ff[NDAI_NS_POS_ERR_BIT] || navst_ff[NDAI_NS_NO_INTEG_BIT];
      radio_on = single_ind && !sat_sel_ff;
      sat_on = single_ind && sat_sel_ff;
      hold_on = hold_ff || navst_ff[NDAI_NS_SEQUENCING_SUSPENDED_BIT];
      gain_on = (sat_sel_ff && (navst_ff[NDAI_NS_SAT_APPR_BIT] || full_scale == NDAI_FS_0P3NM))
         || (!sat_sel_ff && navst_ff[NDAI_NS_LANDING_CH_BIT]);
      guide_on = sat_sel_ff && !gain_on;
   end

   // Registered outputs; lamps pull low when lit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         message_lamp_out <= 1'b1;
         waypoint_lamp_out <= 1'b1;
         terminal_lamp_out <= 1'b1;
         approach_lamp_out <= 1'b1;
         integrity_lamp_out <= 1'b1;
         radio_source_lamp_out <= 1'b1;
         satnav_source_lamp_out <= 1'b1;
         course_hold_lamp_out <= 1'b1;
         approach_gain_out <= 1'b1;
         guidance_select_out <= 1'b1;
         lateral_high_current_flag_out <= 1'b0;
         vertical_high_current_flag_out <= 1'b0;
      end else begin
         message_lamp_out <= ~msg_on;
         waypoint_lamp_out <= ~wpt_on;
         terminal_lamp_out <= ~term_on;
         approach_lamp_out <= ~appr_on;
         integrity_lamp_out <= ~integ_on;
         radio_source_lamp_out <= ~radio_on;
         satnav_source_lamp_out <= ~sat_on;
         course_hold_lamp_out <= ~hold_on;
         approach_gain_out <= ~gain_on;
         guidance_select_out <= ~guide_on;
         lateral_high_current_flag_out <= navst_ff[NDAI_NS_LAT_VALID_BIT];
         vertical_high_current_flag_out <= navst_ff[NDAI_NS_VERT_VALID_BIT];
      end
   end
endmodule

// ==== ndai_chk.sv ====
// Port checker for the navigation discrete annunciator block
`timescale 1ns/100ps
module ndai_chk #(
   parameter int PERIOD_CYC = 200,
   parameter int PULSE_CYC = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic nav_source_toggle_in,
   input wire logic course_mode_toggle_in,
   input wire logic time_mark_out,
   input wire logic radio_source_lamp_out,
   input wire logic satnav_source_lamp_out,
   input wire logic course_hold_lamp_out,
   input wire logic approach_gain_out,
   input wire logic guidance_select_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   int hi_ff;
   int per_ff;
   logic seen_ff;
   // Counters stand in for long repetitions, which would unroll badly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_ff <= 0;
         per_ff <= 0;
         seen_ff <= 1'b0;
      end else begin
         hi_ff <= time_mark_out ? hi_ff + 1 : 0;
         per_ff <= (time_mark_out && hi_ff == 0) ? 1 : per_ff + 1;
         seen_ff <= seen_ff | time_mark_out;
      end
   end
   sequence s_src_press;
      $fell(nav_source_toggle_in) ##1 !nav_source_toggle_in [*4];
   endsequence
   sequence s_mode_press;
      $fell(course_mode_toggle_in) ##1 !course_mode_toggle_in [*4];
   endsequence
   a_src_lamps_excl:
   assert property (radio_source_lamp_out || satnav_source_lamp_out)
      else $error("both source lamps lit");
   a_gain_drops_sel:
   assert property (!approach_gain_out && !$past(approach_gain_out) |-> guidance_select_out)
      else $error("guidance select held with gain active");
   a_sel_not_radio:
   assert property (!guidance_select_out |-> radio_source_lamp_out)
      else $error("guidance select with radio source");
   a_mark_width:
   assert property ($fell(time_mark_out) |-> hi_ff == PULSE_CYC)
      else $error("time mark width wrong");
   a_mark_period:
   assert property ($rose(time_mark_out) && seen_ff |-> per_ff == PERIOD_CYC)
      else $error("time mark period wrong");
   a_src_toggles:
   assert property (s_src_press |-> ##[1:8] $changed(satnav_source_lamp_out))
      else $error("source press gave no swap");
   a_mode_toggles:
   assert property (s_mode_press |-> ##[1:8] $changed(course_hold_lamp_out))
      else $error("mode press gave no change");
   a_held_once:
   assert property (!course_mode_toggle_in [*8] ##1 !course_mode_toggle_in [*8]
      |-> $stable(course_hold_lamp_out))
      else $error("held switch retriggered");
   c_mark: cover property ($rose(time_mark_out) && seen_ff);
   c_hold: cover property ($fell(course_hold_lamp_out));
   c_gain: cover property ($fell(approach_gain_out));
endmodule

bind ndai_nav_discrete_io ndai_chk #(.PERIOD_CYC(PERIOD_CYC), .PULSE_CYC(PULSE_CYC)) chk_u (
   .pclk(pclk), .presetn(presetn), .nav_source_toggle_in(nav_source_toggle_in),
   .course_mode_toggle_in(course_mode_toggle_in), .time_mark_out(time_mark_out),
   .radio_source_lamp_out(radio_source_lamp_out),
   .satnav_source_lamp_out(satnav_source_lamp_out),
   .course_hold_lamp_out(course_hold_lamp_out), .approach_gain_out(approach_gain_out),
   .guidance_select_out(guidance_select_out)
);

// ==== ndai_panel_model.sv ====
// Far-side panel model: momentary switches and the simulation strap
`timescale 1ns/100ps
module ndai_panel_model (
   input wire logic pclk,
   output logic nav_source_toggle_in,
   output logic course_mode_toggle_in,
   output logic preset_recall_in,
   output logic sim_select_in
);
   // Open switches sit at the pull-up level
   initial begin
      nav_source_toggle_in = 1'b1;
      course_mode_toggle_in = 1'b1;
      preset_recall_in = 1'b1;
      sim_select_in = 1'b1;
   end
   // Ground one switch for len cycles, then stay open long enough to rearm
   task automatic press(input int k, input int len);
      logic v;
      for (int i = 0; i < len + 14; i++) begin
         v = (i >= len);
         case (k)
            0: nav_source_toggle_in <= v;
            1: course_mode_toggle_in <= v;
            default: preset_recall_in <= v;
         endcase
         @(posedge pclk);
      end
   endtask
   task automatic set_sim(input logic v);
      sim_select_in <= v;
   endtask
endmodule

// ==== nav_discrete_annunciator_io_tb_top.sv ====
// Self-checking bench for the navigation discrete annunciator block
`timescale 1ns/100ps
module nav_discrete_annunciator_io_tb_top
   import ndai_pkg::*;
;
   localparam int PER = 200;
   localparam int PUL = 10;
   localparam int FL = 8;
   localparam int AL = 2;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic msg, wp, term, appr, integ, rad, sat_l, hold_l, gain, gsel, latf, vertf, tmark;
   logic nav_n, mode_n, rcl_n, sim_n;
   logic [11:0] outs;
   logic sat, single, hold;
   int fs, navst, failures, n_compared, seed;
   int freq[8];
   int fs_tab[4] = '{3, 10, 11, 50};
   int lens[3] = '{8, 30, 2};
   assign outs = {msg, wp, term, appr, integ, rad, sat_l, hold_l, gain, gsel, latf, vertf};
   ndai_nav_discrete_io #(.PERIOD_CYC(PER), .PULSE_CYC(PUL), .FLASH_CYC(FL),
      .DEBOUNCE_CYC(4), .ALARM_SEC(AL), .FREQ_W(20)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nav_source_toggle_in(nav_n), .course_mode_toggle_in(mode_n),
      .preset_recall_in(rcl_n), .sim_select_in(sim_n), .message_lamp_out(msg),
      .waypoint_lamp_out(wp), .terminal_lamp_out(term), .approach_lamp_out(appr),
      .integrity_lamp_out(integ), .radio_source_lamp_out(rad), .satnav_source_lamp_out(sat_l),
      .course_hold_lamp_out(hold_l), .approach_gain_out(gain), .guidance_select_out(gsel),
      .lateral_high_current_flag_out(latf), .vertical_high_current_flag_out(vertf),
      .time_mark_out(tmark));
   ndai_panel_model panel_u (.pclk(pclk), .nav_source_toggle_in(nav_n),
      .course_mode_toggle_in(mode_n), .preset_recall_in(rcl_n), .sim_select_in(sim_n));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Steady lamp levels only; flashing inputs are left to the timed checks
   function automatic logic [11:0] exp_outs();
      logic g;
      int n;
      n = navst;
      g = sat ? (n[12] | (fs == 3)) : n[13];
      return ~{n[1], n[3], n[7] & n[8] & (fs <= 10), n[7] & n[9], n[10] | n[11],
         single & !sat, single & sat, hold | n[14], g, sat & !g, !n[15], !n[16]};
   endfunction
   task automatic setcfg();
      logic [31:0] rd;
      logic er;
      apb(1'b1, NDAI_CTRL_OFS, (32'(fs) << 4) | 32'({hold, sat, single}), rd, er);
      apb(1'b1, NDAI_NAVST_OFS, navst, rd, er);
      repeat (2) @(posedge pclk);
   endtask
   task automatic flash(input int bits, input logic which);
      logic v;
      int n;
      navst = bits;
      setcfg();
      v = which ? wp : msg;
      n = 0;
      while ((which ? wp : msg) === v && n < 100) begin
         @(posedge pclk);
         n++;
      end
      v = which ? wp : msg;
      n = 0;
      while ((which ? wp : msg) === v && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk("flash_gap", FL, n);
   endtask
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      end_sim();
   end
   initial begin
      logic [31:0] rd;
      logic [11:0] e;
      logic er;
      int last;
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      {failures, n_compared, navst} = '0;
      seed = 32'hcf63;
      {sat, single, hold, fs} = {1'b1, 1'b1, 1'b0, 32'd50};
      do_reset();
      chk("reset_outs", exp_outs(), outs);
      apb(1'b0, 12'h010, 0, rd, er);
      chk("unmapped_err", 1, er);
      apb(1'b0, NDAI_STAT_OFS, 0, rd, er);
      chk("sim_mode", 0, rd[11]);
      for (int i = 0; i < 24; i++) begin
         navst = $random(seed) & 32'h0001_FF8A;
         {hold, sat, single} = 3'($random(seed));
         fs = fs_tab[$random(seed) & 3];
         setcfg();
         e = exp_outs();
         chk("status_lamps", e[11:7], outs[11:7]);
         chk("guide_outs", e[6:0], outs[6:0]);
      end
      {sat, single, hold} = 3'b110;
      flash(3, 1'b0);
      flash(4, 1'b1);
      flash(64, 1'b1);
      navst = 32'h0000_000C;
      setcfg();
      chk("turn_steady", 0, wp);
      navst = 32'h0000_0010;
      setcfg();
      navst = 32'h0000_0030;
      setcfg();
      last = 0;
      for (int i = 0; i < 800; i++) begin
         @(posedge pclk);
         if (wp === 1'b0) last = i;
      end
      chk("alarm_span", 1, last > AL * PER - 2 * FL && last < (AL + 1) * PER + FL);
      navst = 0;
      setcfg();
      for (int k = 0; k < 2; k++) begin
         foreach (lens[j]) begin
            panel_u.press(k, lens[j]);
            if (lens[j] > 5 && k == 0) sat = !sat;
            if (lens[j] > 5 && k == 1) hold = !hold;
            chk("switch_outs", exp_outs(), outs);
         end
      end
      for (int i = 0; i < 8; i++) begin
         freq[i] = $random(seed) & 32'h000F_FFFF;
         apb(1'b1, NDAI_PRESET_OFS, (i << 20) | freq[i], rd, er);
      end
      for (int i = 1; i < 10; i++) begin
         panel_u.press(2, 6);
         apb(1'b0, NDAI_PRESET_OFS, 0, rd, er);
         chk("standby", ((i % 8) << 20) | freq[i % 8], rd & 32'h007F_FFFF);
      end
      // Strap low across a second reset, then opened: mode must stick
      panel_u.set_sim(1'b0);
      do_reset();
      repeat (4) @(posedge pclk);
      panel_u.set_sim(1'b1);
      last = 0;
      for (int i = 0; i < 5 * PER; i++) begin
         @(posedge pclk);
         last += tmark;
      end
      chk("mark_high", 5 * PUL, last);
      apb(1'b0, NDAI_STAT_OFS, 0, rd, er);
      chk("sim_mode", 1, rd[11]);
      end_sim();
   end
endmodule
